// *** rtl/memclk_pkg.sv ***
// package: register map, field layout and modes of the memory clock output control
package memclk_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_FIRST_OFFS = 8'h00;
  localparam logic [7:0] CTRL_SECOND_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  // first global control fields
  localparam int FIRST_FLOAT_BIT = 0;
  localparam int FIRST_HOLD_FLOAT_BIT = 1;
  // second global control fields
  localparam int SECOND_MODE_LSB = 0;
  localparam int SECOND_HOLD_FLOAT_BIT = 3;
  // status fields
  localparam int STAT_STRAP_BIT = 0;
  localparam int STAT_SELECT_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_OFF_BIT = 3;
  localparam int STAT_FIRST_OE_N_BIT = 4;
  localparam int STAT_SECOND_OE_N_BIT = 5;
  // reset values of control fields
  localparam logic RST_FIRST_FLOAT = 1'b0;
  localparam logic RST_HOLD_FLOAT = 1'b0;
  // second output modes
  typedef enum logic [2:0]
  {
    MODE_DIV1 = 3'b000,
    MODE_DIV2 = 3'b001,
    MODE_DIV4 = 3'b010,
    MODE_LOW = 3'b011,
    MODE_FLOAT = 3'b100
  } second_mode_e;
  localparam second_mode_e RST_SECOND_MODE = MODE_DIV4;
  // one output pin: level and active low enable
  typedef struct packed
  {
    logic level;
    logic oe_n;
  } pin_s;
endpackage : memclk_pkg

// *** rtl/memclk_ctrl.sv ***
// memory clock source selection and two clock output pins with wishbone control
//
// Functional notes
// - select low uses internal clock, high external
// - first output carries clock, control may float
// - first output floats while reset held low
// - after reset first output follows strap/select
// - second output divides by 1, 2 or 4
// - second output can hold low or float
// - during reset second output runs divided by four
// - after reset second output low or quarter rate
// - hold mode floats output when float bit set
// - out of reset, off mode floats both outputs
// - strap latched at reset release
//
// operating notes
// - both clock sources are sampled as data on CLK, so each must
//   stay below half the CLK rate or edges get lost
// - pin edges land on CLK edges, so every pin clock carries up to
//   one CLK period of jitter against its source
// - the first pin follows the source one CLK edge late: only the
//   pin register, the edge detector is not in its path
// - the source select is read all the time; there is no glitch-free
//   switch, so moving it while the interface runs can leave a runt
//   pulse on either pin and a skipped count in the divider
// - the divider counts rising source edges and is never reset, so
//   the second pin keeps toggling at a quarter rate through reset
// - the divider starts from zero at power up only; a mid-run reset
//   keeps its phase, which the far side cannot tell apart anyway
// - the strap is taken on the first CLK edge after reset release;
//   a strap that moves later is shown nowhere, not even in the status word
// - the first float bit and the second mode are loaded once from strap and select at
//   release; a bus write in that very cycle is dropped on purpose so
//   the boot behaviour always wins
// - off mode and the hold float bits act on the enables only, the
//   pin levels keep running behind them so nothing jumps on return
// - out of reset, off mode beats every other setting, then hold float,
//   then the reset behaviour, then the control registers
// - hold acknowledge is the request delayed by two edges; the
//   external host must keep the request up until it sees the answer
// - the bus answers every request one cycle after it is taken;
//   unmapped addresses read zero and drop writes, and writes need
//   byte lane zero since all fields sit in the low byte
// - read data and ack stand for one cycle only; the master takes the
//   data at the edge at which it sees ack high
// - status shows the enables as they stand on the pins, so a read
//   lags a control write by two cycles at most
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module memclk_ctrl
  import memclk_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic INTERNAL_SYSTEM_CLOCK_THREE,
  input wire logic EXT_MEM_CLOCK_INPUT,
  input wire logic MEM_CLOCK_SOURCE_SELECT,
  input wire logic BOOT_CONFIG_STRAP,
  input wire logic HOLD_REQUEST,
  input wire logic TEST_RESET,
  input wire logic EMULATION_PIN_ZERO,
  input wire logic EMULATION_ONE_OFF_PIN,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic MEM_CLOCK_OUT_FIRST,
  output logic MEM_CLOCK_OUT_FIRST_OE_N,
  output logic MEM_CLOCK_OUT_SECOND,
  output logic MEM_CLOCK_OUT_SECOND_OE_N,
  output logic BUS_HOLD_ACKNOWLEDGE
);

  logic strap_r;
  logic first_float_r;
  logic first_hold_float_r;
  second_mode_e second_mode_r;
  logic second_hold_float_r;
  // the divider has no reset so it keeps running in reset; zero start only
  logic [1:0] div_cnt_r = 2'h0;
  logic src_clk;
  logic src_prev_r = 1'b0;
  logic src_rise;
  logic div2_r = 1'b0;
  logic div4_r = 1'b0;
  logic hold_r;
  logic off_mode;
  logic req;
  logic wr_en;
  pin_s first_nxt;
  pin_s second_nxt;
  logic [31:0] rd_nxt;

  // source mux, sampled as a plain input
  assign src_clk = MEM_CLOCK_SOURCE_SELECT ? EXT_MEM_CLOCK_INPUT : INTERNAL_SYSTEM_CLOCK_THREE;
  assign src_rise = src_clk & ~src_prev_r;
  assign off_mode = ~TEST_RESET & EMULATION_PIN_ZERO & ~EMULATION_ONE_OFF_PIN;
  assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr_en = req & WB_WE_I & WB_SEL_I[0];

  // strap caught on the first clock after reset release
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      strap_r <= 1'b0;
    else if (!strap_taken_r)
      strap_r <= BOOT_CONFIG_STRAP;
  end

  // strap capture window: one shot after release
  logic strap_taken_r;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      strap_taken_r <= 1'b0;
    else
      strap_taken_r <= 1'b1;
  end

  // edge detector and divider on the selected source, left running in reset
  always_ff @(posedge CLK)
  begin
    src_prev_r <= src_clk;
    if (src_rise)
      div_cnt_r <= div_cnt_r + 2'h1;
  end

  // divided clocks keep running in reset, since the second pin toggles then
  always_ff @(posedge CLK)
  begin
    div2_r <= div_cnt_r[0];
    div4_r <= div_cnt_r[1];
  end

  // hold handshake answers the external host
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      hold_r <= 1'b0;
    else
      hold_r <= HOLD_REQUEST & strap_taken_r;
  end

  // control registers and their post-reset values from strap and select
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      first_float_r <= RST_FIRST_FLOAT;
      first_hold_float_r <= RST_HOLD_FLOAT;
      second_mode_r <= RST_SECOND_MODE;
      second_hold_float_r <= RST_HOLD_FLOAT;
    end
    else if (!strap_taken_r)
    begin
      // first clock after release: pick the boot behaviour
      first_float_r <= ~BOOT_CONFIG_STRAP & ~MEM_CLOCK_SOURCE_SELECT;
      second_mode_r <= (~BOOT_CONFIG_STRAP & ~MEM_CLOCK_SOURCE_SELECT) ? MODE_LOW : MODE_DIV4;
    end
    else if (wr_en && WB_ADR_I == CTRL_FIRST_OFFS)
    begin
      first_float_r <= WB_DAT_I[FIRST_FLOAT_BIT];
      first_hold_float_r <= WB_DAT_I[FIRST_HOLD_FLOAT_BIT];
    end
    else if (wr_en && WB_ADR_I == CTRL_SECOND_OFFS)
    begin
      case (WB_DAT_I[SECOND_MODE_LSB +: 3])
        3'b000: second_mode_r <= MODE_DIV1;
        3'b001: second_mode_r <= MODE_DIV2;
        3'b010: second_mode_r <= MODE_DIV4;
        3'b011: second_mode_r <= MODE_LOW;
        default: second_mode_r <= MODE_FLOAT;
      endcase
      second_hold_float_r <= WB_DAT_I[SECOND_HOLD_FLOAT_BIT];
    end
  end

  // pin next values
  always_comb
  begin
    first_nxt.level = src_clk;
    first_nxt.oe_n = first_float_r | ~strap_taken_r;
    if (hold_r && first_hold_float_r)
      first_nxt.oe_n = 1'b1;
    if (off_mode)
      first_nxt.oe_n = 1'b1;
    second_nxt.oe_n = 1'b0;
    case (second_mode_r)
      MODE_DIV1: second_nxt.level = src_clk;
      MODE_DIV2: second_nxt.level = div2_r;
      MODE_DIV4: second_nxt.level = div4_r;
      MODE_LOW: second_nxt.level = 1'b0;
      MODE_FLOAT:
      begin
        second_nxt.level = 1'b0;
        second_nxt.oe_n = 1'b1;
      end
      default: second_nxt.level = 1'b0;
    endcase
    if (!strap_taken_r)
    begin
      second_nxt.level = div4_r;
      second_nxt.oe_n = 1'b0;
    end
    if (hold_r && second_hold_float_r)
      second_nxt.oe_n = 1'b1;
    if (off_mode)
      second_nxt.oe_n = 1'b1;
  end

  // read mux
  always_comb
  begin
    rd_nxt = 32'h0;
    case (WB_ADR_I)
      CTRL_FIRST_OFFS:
      begin
        rd_nxt[FIRST_FLOAT_BIT] = first_float_r;
        rd_nxt[FIRST_HOLD_FLOAT_BIT] = first_hold_float_r;
      end
      CTRL_SECOND_OFFS:
      begin
        rd_nxt[SECOND_MODE_LSB +: 3] = second_mode_r;
        rd_nxt[SECOND_HOLD_FLOAT_BIT] = second_hold_float_r;
      end
      STATUS_OFFS:
      begin
        rd_nxt[STAT_STRAP_BIT] = strap_r;
        rd_nxt[STAT_SELECT_BIT] = MEM_CLOCK_SOURCE_SELECT;
        rd_nxt[STAT_HOLD_BIT] = hold_r;
        rd_nxt[STAT_OFF_BIT] = off_mode;
        rd_nxt[STAT_FIRST_OE_N_BIT] = MEM_CLOCK_OUT_FIRST_OE_N;
        rd_nxt[STAT_SECOND_OE_N_BIT] = MEM_CLOCK_OUT_SECOND_OE_N;
      end
      default: rd_nxt = 32'h0;
    endcase
  end

  // wishbone slave: one-cycle ack, unmapped reads zero, writes ignored
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd_nxt : 32'h0;
    end
  end

  // registered pins; first floats and second runs divided during reset
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      MEM_CLOCK_OUT_FIRST <= 1'b0;
      MEM_CLOCK_OUT_FIRST_OE_N <= 1'b1;
      MEM_CLOCK_OUT_SECOND_OE_N <= 1'b0;
      BUS_HOLD_ACKNOWLEDGE <= 1'b0;
    end
    else
    begin
      MEM_CLOCK_OUT_FIRST <= first_nxt.level;
      MEM_CLOCK_OUT_FIRST_OE_N <= first_nxt.oe_n;
      MEM_CLOCK_OUT_SECOND_OE_N <= second_nxt.oe_n;
      BUS_HOLD_ACKNOWLEDGE <= hold_r;
    end
  end

  // second clock level is not reset so it keeps toggling in reset
  always_ff @(posedge CLK)
  begin
    MEM_CLOCK_OUT_SECOND <= RESETN ? second_nxt.level : div4_r;
  end

endmodule : memclk_ctrl

// *** tb/mem_clk_sink.sv ***
// clock sink standing for the memories on one clock pin
`timescale 1ns/10ps
module mem_clk_sink
(
  input logic CLK,
  input logic LEVEL,
  input logic OE_N,
  input logic CLR,
  output int EDGES
);
  logic prev_r;
  // count rising edges only while the pin is driven
  always @(posedge CLK)
  begin
    prev_r <= LEVEL;
    if (CLR)
      EDGES <= 0;
    else if (LEVEL && !prev_r && !OE_N)
      EDGES <= EDGES + 1;
  end
endmodule : mem_clk_sink

// *** tb/memclk_ctrl_checker.sv ***
// assertions on the memory clock control ports
`timescale 1ns/10ps
module memclk_ctrl_checker
(
  input logic CLK,
  input logic RESETN,
  input logic HOLD_REQUEST,
  input logic TEST_RESET,
  input logic EMULATION_PIN_ZERO,
  input logic EMULATION_ONE_OFF_PIN,
  input logic WB_CYC_I,
  input logic WB_STB_I,
  input logic WB_ACK_O,
  input logic MEM_CLOCK_OUT_FIRST_OE_N,
  input logic MEM_CLOCK_OUT_SECOND_OE_N,
  input logic BUS_HOLD_ACKNOWLEDGE
);
  // all checks on the system clock, quiet in reset
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  a_first_rst_float: assert property ($rose(RESETN) |-> $past(MEM_CLOCK_OUT_FIRST_OE_N))
    else $error("first pin driven");
  a_second_rst_run: assert property ($rose(RESETN) |-> !$past(MEM_CLOCK_OUT_SECOND_OE_N))
    else $error("second pin floated");
  a_off_floats: assert property (!TEST_RESET & EMULATION_PIN_ZERO & !EMULATION_ONE_OFF_PIN
    |=> MEM_CLOCK_OUT_FIRST_OE_N & MEM_CLOCK_OUT_SECOND_OE_N) else $error("pin driven when off");
  a_hold_ack: assert property ($rose(HOLD_REQUEST) |-> ##[1:3] BUS_HOLD_ACKNOWLEDGE)
    else $error("no hold ack");
  a_hold_drop: assert property ($fell(HOLD_REQUEST) |-> ##[1:3] !BUS_HOLD_ACKNOWLEDGE)
    else $error("hold ack stuck");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_answer: assert property (WB_CYC_I & WB_STB_I & !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  a_ack_idle: assert property (!(WB_CYC_I & WB_STB_I) |=> !WB_ACK_O)
    else $error("stray ack");
endmodule : memclk_ctrl_checker
bind memclk_ctrl memclk_ctrl_checker checker_i (.*);

// *** tb/memclk_ctrl_test.sv ***
// self-checking bench for the memory clock output control
`timescale 1ns/10ps
module memclk_ctrl_test
  import memclk_pkg::*;
;
  logic CLK = 0, RESETN = 0, INTERNAL_SYSTEM_CLOCK_THREE = 0, EXT_MEM_CLOCK_INPUT = 0, HOLD_REQUEST = 0;
  logic MEM_CLOCK_SOURCE_SELECT = 0, BOOT_CONFIG_STRAP = 0, TEST_RESET = 1, EMULATION_PIN_ZERO = 0;
  logic EMULATION_ONE_OFF_PIN = 0, WB_WE_I = 0, WB_CYC_I = 0, WB_STB_I = 0, clr = 0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, q;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [2:0] div_r = 3'h0;
  logic WB_ACK_O, MEM_CLOCK_OUT_FIRST, MEM_CLOCK_OUT_FIRST_OE_N, MEM_CLOCK_OUT_SECOND;
  logic MEM_CLOCK_OUT_SECOND_OE_N, BUS_HOLD_ACKNOWLEDGE;
  int fails = 0, total_checks = 0, n1, n2;
  int e2[5] = '{16, 8, 4, 0, 0};
  memclk_ctrl DUT (.*);
  mem_clk_sink sink1 (.CLK, .LEVEL(MEM_CLOCK_OUT_FIRST), .OE_N(MEM_CLOCK_OUT_FIRST_OE_N), .CLR(clr), .EDGES(n1));
  mem_clk_sink sink2 (.CLK, .LEVEL(MEM_CLOCK_OUT_SECOND), .OE_N(MEM_CLOCK_OUT_SECOND_OE_N), .CLR(clr), .EDGES(n2));
  always #10 CLK = ~CLK;
  // sources: external at CLK/4, internal at CLK/8
  always @(posedge CLK)
  begin
    div_r <= div_r + 3'h1;
    EXT_MEM_CLOCK_INPUT <= div_r[1];
    INTERNAL_SYSTEM_CLOCK_THREE <= div_r[2];
  end
  task automatic chk(input bit ok);
    total_checks++;
    if (!ok)
    begin
      fails++;
      $display("mismatch at %0t check %0d", $time, total_checks);
    end
  endtask : chk
  // driven edges over 64 cycles, then both enables
  task automatic meas(input int a, input int b, input logic z1, input logic z2);
    clr <= 1;
    @(posedge CLK);
    clr <= 0;
    repeat (64) @(posedge CLK);
    chk(n1 inside {[a - 1:a + 1]} && n2 inside {[b - 1:b + 1]});
    chk(MEM_CLOCK_OUT_FIRST_OE_N === z1 && MEM_CLOCK_OUT_SECOND_OE_N === z2);
  endtask : meas
  task automatic rst(input logic s, input logic c, input int b);
    RESETN <= 0;
    BOOT_CONFIG_STRAP <= s;
    MEM_CLOCK_SOURCE_SELECT <= c; // changed only in reset
    meas(0, b, 1'b1, 1'b0);
    RESETN <= 1;
    repeat (2) @(posedge CLK);
  endtask : rst
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {WB_CYC_I, WB_STB_I} <= 2'h3;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    @(posedge CLK);
    for (int i = 0; i < 20 && WB_ACK_O !== 1'b1; i++)
      @(posedge CLK);
    chk(WB_ACK_O === 1'b1);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
    @(posedge CLK);
  endtask : wb
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // watchdog at 10000 cycles, far past the some 820 cycles the tests need
  initial
  begin
    #200000;
    fails++;
    $display("mismatch at %0t watchdog expired", $time);
    print_verdict;
  end
  // test sequence
  initial
  begin
    repeat (5) @(posedge CLK);
    RESETN <= 1;
    repeat (2) @(posedge CLK);
    BOOT_CONFIG_STRAP <= 1;
    meas(0, 0, 1'b1, 1'b0);
    wb(0, STATUS_OFFS, 0);
    chk(q[5:0] === 6'h10);
    rst(1, 0, 2);
    meas(8, 2, 1'b0, 1'b0);
    rst(0, 1, 4);
    for (int i = 0; i < 5; i++)
    begin
      wb(1, CTRL_SECOND_OFFS, 32'(i));
      meas(16, e2[i], 1'b0, i == 4);
    end
    wb(1, CTRL_FIRST_OFFS, 32'h1);
    meas(0, 0, 1'b1, 1'b1);
    wb(1, CTRL_FIRST_OFFS, 32'h2);
    wb(1, CTRL_SECOND_OFFS, 32'h1);
    HOLD_REQUEST <= 1;
    meas(0, 8, 1'b1, 1'b0);
    HOLD_REQUEST <= 0;
    TEST_RESET <= 0;
    EMULATION_PIN_ZERO <= 1;
    meas(0, 0, 1'b1, 1'b1);
    TEST_RESET <= 1;
    wb(0, 8'h0c, 0);
    chk(q === 32'h0);
    print_verdict;
  end
endmodule : memclk_ctrl_test
